// file: src/lcdpw_pkg.sv
// Constants and types shared by both ends of the parallel write port.
// Assumes one 20 MHz clock and a synchronous active-high reset on each end.
// Notes on behaviour
// R1: Select low enables transfers, high ignores bus
// R2: Reset low resets; release before transfers
// R3: Select line 1 data/parameter, 0 command
// R4: Host sets selector, select, data, then strobe; code sets data together with selector, before select
// R5: Device latches word on strobe rising edge
// R6: Host raises select after strobe returns high
// R7: Pixel is 16-bit 565: 5R 6G 5B
// R8: Address walks rows/columns, direction by scan mode
// R9: Host sets address before writing colour
// R10: Frame memory 345600 bytes, 480x320 array; code holds 480x320 16-bit words, 307200 bytes
// R11: Lines 0-7 low byte, 8-15 high
// R12: Port configured for sixteen data lines
// R13: Write-only port, nothing read back
package lcdpw_pkg;
   localparam int unsigned LCDPW_DATA_W = 16;
   localparam int unsigned LCDPW_COLS = 480;
   localparam int unsigned LCDPW_ROWS = 320;
   localparam int unsigned LCDPW_MEM_BYTES = 345600;
   localparam int unsigned LCDPW_PIXELS = LCDPW_COLS * LCDPW_ROWS;
   localparam int unsigned LCDPW_COL_W = 9;
   localparam int unsigned LCDPW_ROW_W = 9;
   localparam int unsigned LCDPW_ADDR_W = 18;
   // Field positions of a 565 pixel
   localparam int unsigned LCDPW_RED_LSB = 11;
   localparam int unsigned LCDPW_GRN_LSB = 5;
   localparam int unsigned LCDPW_BLU_LSB = 0;
   // Command codes used by the address walker
   localparam logic [7:0] LCDPW_CMD_COL_SET = 8'h2A;
   localparam logic [7:0] LCDPW_CMD_ROW_SET = 8'h2B;
   localparam logic [7:0] LCDPW_CMD_MEM_WR = 8'h2C;
   localparam logic [7:0] LCDPW_CMD_SCAN = 8'h36;
   // Scan mode bits: row decrement, column decrement
   localparam int unsigned LCDPW_SCAN_ROWDEC = 7;
   localparam int unsigned LCDPW_SCAN_COLDEC = 6;
   // Reset values
   localparam logic [8:0] LCDPW_COL_RST = 9'h000;
   localparam logic [8:0] LCDPW_ROW_RST = 9'h000;
   // Host timing: each strobe phase in ns, converted to 50 ns cycles
   localparam int unsigned LCDPW_CLK_NS = 50;
   localparam int unsigned LCDPW_PHASE_NS = 50;
   localparam int unsigned LCDPW_PHASE_CYC = (LCDPW_PHASE_NS + LCDPW_CLK_NS - 1) / LCDPW_CLK_NS;
   localparam logic [3:0] LCDPW_PHASE_CNT = 4'(LCDPW_PHASE_CYC < 1 ? 1 : LCDPW_PHASE_CYC);
   typedef enum logic [2:0] {
      LCDPW_H_IDLE = 3'b000,
      LCDPW_H_SEL = 3'b001,
      LCDPW_H_DATA = 3'b010,
      LCDPW_H_STB = 3'b011,
      LCDPW_H_REL = 3'b100,
      LCDPW_H_DESEL = 3'b101
   } lcdpw_hstate_t;
   // Flattened frame address for a column and row
   function automatic logic [17:0] lcdpw_addr(input logic [8:0] col, input logic [8:0] row);
      lcdpw_addr = 18'(row * LCDPW_COLS + col);
   endfunction : lcdpw_addr
endpackage : lcdpw_pkg

// file: src/lcdpw_if.sv
// Pin group between the host and the display port.
// Assumes both ends share the 20 MHz clock; all pins are host-driven.
interface lcdpw_if;
   import lcdpw_pkg::*;
   logic bus_select_n;
   logic ext_reset_n;
   logic cmd_data_sel;
   logic write_strobe_n;
   logic [LCDPW_DATA_W-1:0] data;
   modport host (output bus_select_n, output ext_reset_n, output cmd_data_sel, output write_strobe_n, output data);
   modport device (input bus_select_n, input ext_reset_n, input cmd_data_sel, input write_strobe_n, input data);
endinterface : lcdpw_if

// file: src/lcdpw_device.sv
// Display end: latches words on the strobe rising edge and writes frame memory.
// Assumes pins synchronous to i_clk and timing held by the host.
module lcdpw_device
   import lcdpw_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   lcdpw_if.device bus,
   output logic o_word_valid,
   output logic o_word_is_cmd,
   output logic [15:0] o_word,
   output logic o_pix_valid,
   output logic [17:0] o_pix_addr,
   output logic [4:0] o_red,
   output logic [5:0] o_green,
   output logic [4:0] o_blue
);
   typedef struct packed {
      logic strobe_n;
      logic word_valid;
      logic word_is_cmd;
      logic [15:0] word;
      logic [7:0] last_cmd;
      logic [1:0] parm_idx;
      logic [7:0] scan;
      logic [8:0] col_start;
      logic [8:0] col_end;
      logic [8:0] row_start;
      logic [8:0] row_end;
      logic [8:0] col;
      logic [8:0] row;
      logic pix_valid;
      logic [17:0] pix_addr;
      logic [15:0] pix;
   } lcdpw_dstate_t;
   lcdpw_dstate_t st_ff, nxt_st;
   // Frame memory, one 16-bit word per pixel
   logic [15:0] frame_memory [LCDPW_PIXELS]; // R10
   logic rise;
   logic [7:0] pbyte;

   ////////////////////////////////////////////////////////////////////////
   // Decode a strobe rising edge; select and reset qualify it
   assign rise = st_ff.strobe_n == 1'b0 && bus.write_strobe_n == 1'b1
                 && bus.bus_select_n == 1'b0 && bus.ext_reset_n == 1'b1; // R1 R2 R5
   assign pbyte = bus.data[7:0];

   always_comb begin
      nxt_st = st_ff;
      nxt_st.strobe_n = bus.write_strobe_n;
      nxt_st.word_valid = 1'b0;
      nxt_st.pix_valid = 1'b0;
      if (bus.ext_reset_n == 1'b0) begin // R2
         nxt_st.scan = 8'h00;
         nxt_st.col = LCDPW_COL_RST;
         nxt_st.row = LCDPW_ROW_RST;
         nxt_st.last_cmd = 8'h00;
         nxt_st.parm_idx = 2'b00;
         // Window back to the full array, so a later write starts at zero
         nxt_st.col_start = LCDPW_COL_RST;
         nxt_st.row_start = LCDPW_ROW_RST;
         nxt_st.col_end = 9'(LCDPW_COLS - 1);
         nxt_st.row_end = 9'(LCDPW_ROWS - 1);
      end else if (rise) begin
         nxt_st.word_valid = 1'b1;
         nxt_st.word = bus.data; // R11 R12
         nxt_st.word_is_cmd = ~bus.cmd_data_sel; // R3
         if (bus.cmd_data_sel == 1'b0) begin
            nxt_st.last_cmd = bus.data[7:0];
            nxt_st.parm_idx = 2'b00;
            if (bus.data[7:0] == LCDPW_CMD_MEM_WR) begin
               nxt_st.col = st_ff.col_start;
               nxt_st.row = st_ff.row_start;
            end
         end else begin
            nxt_st.parm_idx = st_ff.parm_idx + 2'b01;
            unique case (st_ff.last_cmd)
               LCDPW_CMD_SCAN: nxt_st.scan = bus.data[7:0];
               LCDPW_CMD_COL_SET: begin
                  unique case (st_ff.parm_idx)
                     2'b00: nxt_st.col_start[8] = pbyte[0];
                     2'b01: nxt_st.col_start[7:0] = pbyte[7:0];
                     2'b10: nxt_st.col_end[8] = pbyte[0];
                     2'b11: nxt_st.col_end[7:0] = pbyte[7:0];
                  endcase
               end
               LCDPW_CMD_ROW_SET: begin
                  unique case (st_ff.parm_idx)
                     2'b00: nxt_st.row_start[8] = pbyte[0];
                     2'b01: nxt_st.row_start[7:0] = pbyte[7:0];
                     2'b10: nxt_st.row_end[8] = pbyte[0];
                     2'b11: nxt_st.row_end[7:0] = pbyte[7:0];
                  endcase
               end
               LCDPW_CMD_MEM_WR: begin
                  // Pixel write, then advance column then row
                  nxt_st.pix_valid = 1'b1;
                  nxt_st.pix = bus.data; // R7
                  nxt_st.pix_addr = lcdpw_addr(st_ff.col, st_ff.row);
                  nxt_st.parm_idx = st_ff.parm_idx;
                  if (st_ff.col == st_ff.col_end) begin // R8
                     nxt_st.col = st_ff.col_start;
                     if (st_ff.row == st_ff.row_end) begin
                        nxt_st.row = st_ff.row_start;
                     end else if (st_ff.scan[LCDPW_SCAN_ROWDEC]) begin
                        nxt_st.row = st_ff.row - 9'h001;
                     end else begin
                        nxt_st.row = st_ff.row + 9'h001;
                     end
                  end else if (st_ff.scan[LCDPW_SCAN_COLDEC]) begin
                     nxt_st.col = st_ff.col - 9'h001;
                  end else begin
                     nxt_st.col = st_ff.col + 9'h001;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; the pin reset also clears scan and address
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_ff <= '0;
         st_ff.strobe_n <= 1'b1;
         st_ff.col_end <= 9'(LCDPW_COLS - 1);
         st_ff.row_end <= 9'(LCDPW_ROWS - 1);
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Out-of-range addresses are dropped rather than wrapped
   always_ff @(posedge i_clk) begin
      if (st_ff.pix_valid && st_ff.pix_addr < 18'(LCDPW_PIXELS)) begin
         frame_memory[st_ff.pix_addr] <= st_ff.pix;
      end
   end

   assign o_word_valid = st_ff.word_valid;
   assign o_word_is_cmd = st_ff.word_is_cmd;
   assign o_word = st_ff.word;
   assign o_pix_valid = st_ff.pix_valid;
   assign o_pix_addr = st_ff.pix_addr;
   assign o_red = st_ff.pix[15:LCDPW_RED_LSB]; // R7
   assign o_green = st_ff.pix[10:LCDPW_GRN_LSB];
   assign o_blue = st_ff.pix[4:LCDPW_BLU_LSB];
endmodule : lcdpw_device

// file: src/lcdpw_host.sv
// Host end: sequences select, selector, data and strobe for each word.
// Assumes the user holds a request until accepted; nothing is read back.
module lcdpw_host
   import lcdpw_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   lcdpw_if.host bus,
   input wire logic i_panel_reset,
   input wire logic i_req,
   input wire logic i_is_cmd,
   input wire logic [15:0] i_word,
   output logic o_ready,
   output logic o_done
);
   typedef struct packed {
      lcdpw_hstate_t state;
      logic [3:0] cnt;
      logic sel_n;
      logic rst_n;
      logic dc;
      logic stb_n;
      logic [15:0] data;
      logic ready;
      logic done;
   } lcdpw_hregs_t;
   lcdpw_hregs_t st_ff, nxt_st;

   ////////////////////////////////////////////////////////////////////////
   // Write sequencer, one phase per step
   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.rst_n = ~i_panel_reset; // R2
      if (st_ff.cnt != 4'h0) begin
         nxt_st.cnt = st_ff.cnt - 4'h1;
      end else begin
         unique case (st_ff.state)
            LCDPW_H_IDLE: begin
               if (i_req && st_ff.ready && !i_panel_reset) begin
                  nxt_st.dc = ~i_is_cmd; // R3 R4
                  nxt_st.data = i_word;
                  nxt_st.ready = 1'b0;
                  nxt_st.state = LCDPW_H_SEL;
                  nxt_st.cnt = LCDPW_PHASE_CNT - 4'h1;
               end
            end
            LCDPW_H_SEL: begin
               nxt_st.sel_n = 1'b0; // R1 R4
               nxt_st.state = LCDPW_H_DATA;
               nxt_st.cnt = LCDPW_PHASE_CNT - 4'h1;
            end
            LCDPW_H_DATA: begin
               nxt_st.stb_n = 1'b0; // R4
               nxt_st.state = LCDPW_H_STB;
               nxt_st.cnt = LCDPW_PHASE_CNT - 4'h1;
            end
            LCDPW_H_STB: begin
               nxt_st.stb_n = 1'b1; // R5
               nxt_st.state = LCDPW_H_REL;
               nxt_st.cnt = LCDPW_PHASE_CNT - 4'h1;
            end
            LCDPW_H_REL: begin
               nxt_st.sel_n = 1'b1; // R6
               nxt_st.state = LCDPW_H_DESEL;
            end
            LCDPW_H_DESEL: begin
               nxt_st.done = 1'b1;
               nxt_st.ready = 1'b1;
               nxt_st.state = LCDPW_H_IDLE;
            end
            default: nxt_st.state = LCDPW_H_IDLE;
         endcase
      end
   end

   // Data bus is driven on every cycle; the port is write-only
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_ff <= '0;
         st_ff.state <= LCDPW_H_IDLE;
         st_ff.sel_n <= 1'b1;
         st_ff.rst_n <= 1'b0;
         st_ff.dc <= 1'b1;
         st_ff.stb_n <= 1'b1;
         st_ff.ready <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bus.bus_select_n = st_ff.sel_n;
   assign bus.ext_reset_n = st_ff.rst_n;
   assign bus.cmd_data_sel = st_ff.dc;
   assign bus.write_strobe_n = st_ff.stb_n;
   assign bus.data = st_ff.data; // R11 R13
   assign o_ready = st_ff.ready;
   assign o_done = st_ff.done;
endmodule : lcdpw_host

// file: test/lcdpw_monitor.sv
// Wire checks on the pin group between host end and display end.
// Assumes one shared clock; instantiated beside the interface in tb_top.
module lcdpw_monitor
   import lcdpw_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic bus_select_n,
   input wire logic ext_reset_n,
   input wire logic cmd_data_sel,
   input wire logic write_strobe_n,
   input wire logic [LCDPW_DATA_W-1:0] data
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////////////
   // Strobe framing inside one selected transfer
   a_strobe_in_select: assert property (!write_strobe_n |-> !bus_select_n && ext_reset_n)
      else $error("strobe low outside select");
   a_select_then_strobe: assert property ($fell(bus_select_n) |=> $fell(write_strobe_n))
      else $error("strobe did not follow select");
   a_strobe_one_cycle: assert property ($fell(write_strobe_n) |=> $rose(write_strobe_n))
      else $error("strobe low length wrong");
   // Selector and word must be settled before select falls and held over the strobe rise; select is low three cycles, then released
   a_setup_before_select: assert property ($fell(bus_select_n) |-> $stable(cmd_data_sel) && $stable(data))
      else $error("word changed at select");
   a_hold_over_rise: assert property (!write_strobe_n |=> $stable(data) && $stable(cmd_data_sel))
      else $error("word changed across strobe rise");
   a_select_release: assert property ($rose(write_strobe_n) |-> !bus_select_n ##1 bus_select_n)
      else $error("select not released after strobe");
   a_select_span: assert property ($fell(bus_select_n) |-> (!bus_select_n)[*3] ##1 bus_select_n)
      else $error("select low span wrong");
   // Panel reset keeps the bus quiet
   a_reset_quiet: assert property (!ext_reset_n |-> bus_select_n && write_strobe_n)
      else $error("transfer during panel reset");
   ////////////////////////////////////////////////////////////////////////////
   // Main traffic kinds
   c_cmd_word: cover property ($rose(write_strobe_n) && !cmd_data_sel);
   c_data_word: cover property ($rose(write_strobe_n) && cmd_data_sel);
   c_panel_reset: cover property ($fell(ext_reset_n));
endmodule : lcdpw_monitor

// file: test/tb_top.sv
// Host end driving display end through the pin group, with word checks.
// Assumes the package, interface and both ends compiled before this file.
module tb_top
   import lcdpw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 1'b0;
   logic i_rst, i_panel_reset, i_req, i_is_cmd, o_ready, o_done;
   logic [15:0] i_word, o_word;
   logic o_word_valid, o_word_is_cmd, o_pix_valid, seen;
   logic [17:0] o_pix_addr;
   logic [4:0] o_red, o_blue;
   logic [5:0] o_green;
   logic [15:0] win [8] = '{16'h0001, 16'h00DE, 16'h0001, 16'h00DF, 16'h0001, 16'h003E, 16'h0001, 16'h003F};
   int n_mismatch = 0;
   int samples_checked = 0;
   lcdpw_if bus_if ();
   lcdpw_host i_lcdpw_host (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_if.host), .i_panel_reset(i_panel_reset),
      .i_req(i_req), .i_is_cmd(i_is_cmd), .i_word(i_word), .o_ready(o_ready), .o_done(o_done));
   lcdpw_device i_lcdpw_device (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_if.device), .o_word_valid(o_word_valid),
      .o_word_is_cmd(o_word_is_cmd), .o_word(o_word), .o_pix_valid(o_pix_valid), .o_pix_addr(o_pix_addr),
      .o_red(o_red), .o_green(o_green), .o_blue(o_blue));
   lcdpw_monitor i_lcdpw_monitor (.i_clk(i_clk), .i_rst(i_rst), .bus_select_n(bus_if.bus_select_n),
      .ext_reset_n(bus_if.ext_reset_n), .cmd_data_sel(bus_if.cmd_data_sel),
      .write_strobe_n(bus_if.write_strobe_n), .data(bus_if.data));
   ////////////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   always #25 i_clk = ~i_clk;
   task automatic check(input string name, input logic [17:0] got, input logic [17:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %0h seen %0h", name, exp, got);
      end
   endtask : check
   task automatic give_verdict();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   // One word through both ends; request held until the taking edge
   task automatic send(input logic c, input logic [15:0] w, input logic px, input logic [17:0] a);
      int n;
      @(posedge i_clk);
      i_req <= 1'b1;
      i_is_cmd <= c;
      i_word <= w;
      // Outputs are looked at on the falling edge, where they are settled
      do @(negedge i_clk); while (o_ready !== 1'b1);
      @(posedge i_clk);
      i_req <= 1'b0;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (o_word_valid !== 1'b1 && n < 20);
      check("word_valid", 18'(o_word_valid), 18'h00001);
      check("word", 18'(o_word), 18'(w));
      check("word_is_cmd", 18'(o_word_is_cmd), 18'(c));
      check("cmd_data_sel", 18'(bus_if.cmd_data_sel), 18'(!c));
      check("bus_data", 18'(bus_if.data), 18'(w));
      check("pix_valid", 18'(o_pix_valid), 18'(px));
      if (px) begin
         check("pix_addr", o_pix_addr, a);
         check("red", 18'(o_red), 18'(w[15:11]));
         check("green", 18'(o_green), 18'(w[10:5]));
         check("blue", 18'(o_blue), 18'(w[4:0]));
      end
      @(negedge i_clk);
      check("done", 18'(o_done), 18'h00001);
   endtask : send
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      i_rst = 1'b1;
      i_panel_reset = 1'b0;
      i_req = 1'b0;
      i_is_cmd = 1'b0;
      i_word = 16'h0000;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (2) @(negedge i_clk);
      check("ext_reset_n", 18'(bus_if.ext_reset_n), 18'h00001);
      check("bus_select_n", 18'(bus_if.bus_select_n), 18'h00001);
      // Window at the last two columns and rows, to hit both wraps
      for (int i = 0; i < 8; i++) begin
         if (i % 4 == 0) send(1'b1, (i == 0) ? 16'h002A : 16'h002B, 1'b0, 18'h00000);
         send(1'b0, win[i], 1'b0, 18'h00000);
      end
      send(1'b1, 16'h002C, 1'b0, 18'h00000);
      for (int i = 0; i < 5; i++) begin
         send(1'b0, 16'(16'hF800 + i * 16'h07E1), 1'b1, 18'((318 + (i % 4) / 2) * LCDPW_COLS + 478 + i % 2));
      end
      // Requests refused while the panel is held in reset
      @(posedge i_clk);
      i_panel_reset <= 1'b1;
      i_req <= 1'b1;
      seen = 1'b0;
      repeat (10) begin
         @(negedge i_clk);
         seen = seen | o_word_valid;
      end
      check("refused", 18'(seen), 18'h00000);
      check("ext_reset_n", 18'(bus_if.ext_reset_n), 18'h00000);
      @(posedge i_clk);
      i_panel_reset <= 1'b0;
      i_req <= 1'b0;
      repeat (2) @(posedge i_clk);
      // Address state cleared by the panel reset
      send(1'b1, 16'h002C, 1'b0, 18'h00000);
      send(1'b0, 16'h07E0, 1'b1, 18'h00000);
      give_verdict();
   end
   // Watchdog well beyond the roughly 160 cycles the tests need
   initial begin
      repeat (5000) @(posedge i_clk);
      n_mismatch++;
      give_verdict();
   end
endmodule : tb_top
